/* File: src/panel_rail_pkg.sv */
// Shared constants and types for the panel rail sequencer
package panel_rail_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] GL_VOLT_ADDR    = 8'h04;
	localparam logic [7:0] GH_VOLT_ADDR    = 8'h05;
	localparam logic [7:0] CORE_VOLT_ADDR  = 8'h07;
	localparam logic [7:0] ANALOG_SEQ_ADDR = 8'h0f;
	localparam logic [7:0] GL_PUMP_ADDR    = 8'h10;
	localparam logic [7:0] GH_BOOST_ADDR   = 8'h11;
	localparam logic [7:0] CORE_SEQ_ADDR   = 8'h20;
	localparam logic [7:0] RAIL_EN_ADDR    = 8'h21;
	localparam logic [7:0] STATUS_ADDR     = 8'h22;

	// ------------------------------------------------------------
	// Reset values and writable-bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] GL_VOLT_RST    = 8'h24;
	localparam logic [7:0] GH_VOLT_RST    = 8'h0c;
	localparam logic [7:0] CORE_VOLT_RST  = 8'h08;
	localparam logic [7:0] ANALOG_SEQ_RST = 8'h02;
	localparam logic [7:0] GL_PUMP_RST    = 8'h2a;
	localparam logic [7:0] GH_BOOST_RST   = 8'h24;
	localparam logic [7:0] CORE_SEQ_RST   = 8'h01;
	localparam logic [7:0] RAIL_EN_RST    = 8'h0f;
	localparam logic [7:0] GL_VOLT_MASK   = 8'h7f;
	localparam logic [7:0] GH_VOLT_MASK   = 8'h3f;
	localparam logic [7:0] CORE_VOLT_MASK = 8'h1f;
	localparam logic [7:0] SEQ_MASK       = 8'h1f;
	localparam logic [7:0] CORE_SEQ_MASK  = 8'h03;
	localparam logic [7:0] RAIL_EN_MASK   = 8'h0f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FREQ_LSB   = 5;
	localparam int SS_LSB     = 3;
	localparam int DLY_LSB    = 0;
	localparam int GL_CLK_BIT = 5;
	localparam int ARCH_LSB   = 6;
	localparam int FAULT_BIT  = 4;
	localparam int UNDERVOLTAGE_LOCKOUT_BIT   = 7;

	// Rail indices in enable and status vectors
	localparam int RAIL_AN   = 0;
	localparam int RAIL_GH   = 1;
	localparam int RAIL_GL   = 2;
	localparam int RAIL_CORE = 3;
	localparam int N_RAILS   = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         CLK_MHZ      = 10;
	localparam int         TICK_US      = 1000;
	localparam int         TICK_W       = 14;
	localparam logic [7:0] DLY_STEP_MS  = 8'h05;
	localparam logic [7:0] AN_SS_MS     = 8'h05;
	localparam logic [7:0] GATE_SS_MS   = 8'h02;
	localparam logic [7:0] CORE_STEP_MS = 8'h03;
	localparam logic [5:0] FAULT_MS     = 6'h3c;
	localparam logic [7:0] ELAPSED_MAX  = 8'hff;

	// ------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR_DFLT = 7'h2c;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ADDR  = 3'b001,
		S_AACK  = 3'b010,
		S_REG   = 3'b011,
		S_RACKD = 3'b100,
		S_WDATA = 3'b101,
		S_WACK  = 3'b110,
		S_RDATA = 3'b111
	} serial_state_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	typedef struct packed {
		logic core;
		logic gate_low;
		logic gate_high;
		logic analog;
	} rail_vec_t;

endpackage

/* File: src/panel_rail_sequencer_config.sv */
// Rail sequencing, fault shutdown and configuration registers
// Functional notes
// RQ1 - Gate-high switching frequency code sits in bits 7:5 of 0x11, reset code 1.
// RQ2 - Gate-high soft-start is bits 4:3 of 0x11, 2 ms per step plus 2 ms, reset code 0.
// RQ3 - Gate-high start delay is bits 2:0 of 0x11, 5 ms per code from analog ready, reset 4.
// RQ4 - Gate-high below 80 percent for 60 ms shuts all rails until a new lockout cycle.
// RQ5 - Gate-high voltage code is bits 5:0 of 0x05, reset 0x0c; host restarts after change.
// RQ6 - Gate-low voltage code is bits 6:0 of 0x04, reset 0x24.
// RQ7 - Bit 5 of 0x10 picks full (1, reset) or half analog boost clock for the pump.
// RQ8 - Gate-low soft-start is bits 4:3 of 0x10, 2 ms per step plus 2 ms, reset code 1.
// RQ9 - Gate-low delay is bits 2:0 of 0x10, 5 ms steps from analog start, reset code 2.
// RQ10 - Gate-low below 80 percent for 60 ms shuts all rails until a new lockout cycle.
// RQ11 - Host picks the gate-low architecture mode in bits 7:6 of 0x10.
// RQ12 - Core buck voltage code is the low 5 bits of 0x07, reset 0x08.
// RQ13 - Core start delay is a 2-bit code of 3 ms steps from lockout release, reset 1.
// RQ14 - Analog soft-start is bits 4:3 of 0x0f, 5 ms per step plus 5 ms.
// RQ15 - Analog start delay is bits 2:0 of 0x0f, 5 ms steps from lockout release, reset 2.
// RQ16 - All timers count a millisecond tick and restart when lockout reasserts.
// RQ17 - A fault latch kills every enable and ignores enable writes until lockout cycles.
`timescale 1ns/10ps
module panel_rail_sequencer_config
	import panel_rail_pkg::*;
#(
	parameter int         TICK_CYCLES = CLK_MHZ * TICK_US,
	parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DFLT
) (
	input  wire logic  i_core_clk,
	input  wire logic  i_nrst,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output logic       o_sda_out,
	output logic       o_sda_oe,
	input  wire logic  i_undervoltage_lockout_ok,
	input  wire logic  i_gate_high_low,
	input  wire logic  i_gate_low_low,
	output rail_vec_t  o_rail_en,
	output rail_vec_t  o_rail_ramp,
	output logic       o_fault,
	output logic [5:0] o_gate_high_volt,
	output logic [2:0] o_gate_high_freq,
	output logic [6:0] o_gate_low_volt,
	output logic       o_gate_low_full_clk,
	output logic [1:0] o_gate_low_arch,
	output logic [4:0] o_core_volt
);

	function automatic logic [7:0] span_ms(input logic [2:0] code, input logic [7:0] step,
		input logic plus_one);
		span_ms = ({5'h00, code} + {7'h00, plus_one}) * step;
	endfunction

	logic [2:0]        meta_q;
	logic [2:0]        sync_q;
	logic              undervoltage_lockout_s;
	logic [1:0]        low_s;
	logic [7:0]        gl_volt_q;
	logic [7:0]        gh_volt_q;
	logic [7:0]        core_volt_q;
	logic [7:0]        an_seq_q;
	logic [7:0]        gl_pump_q;
	logic [7:0]        gh_boost_q;
	logic [7:0]        core_seq_q;
	logic [7:0]        rail_en_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic              tick;
	logic [7:0]        elapsed_q;
	logic [N_RAILS-1:0] en_q;
	logic [N_RAILS-1:0] rdy_q;
	logic [N_RAILS-1:0] prereq;
	logic [7:0]        start_ms [N_RAILS];
	logic [7:0]        ready_ms [N_RAILS];
	logic [5:0]        fcnt_q [2];
	logic [1:0]        trip;
	logic [1:0]        watch_rdy;
	logic              fault_q;
	logic [7:0]        rd_data;
	logic [7:0]        reg_addr;
	reg_wr_t           wr;

	// ------------------------------------------------------------
	// Register access port
	// ------------------------------------------------------------
	serial_reg_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.i_rd_data  (rd_data),
		.o_sda_out  (o_sda_out),
		.o_sda_oe   (o_sda_oe),
		.o_reg_addr (reg_addr),
		.o_wr       (wr)
	);

	// ------------------------------------------------------------
	// Analog status synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			meta_q <= {i_gate_low_low, i_gate_high_low, i_undervoltage_lockout_ok};
			sync_q <= meta_q;
		end
	end

	assign undervoltage_lockout_s = sync_q[0];
	assign low_s  = sync_q[2:1];

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			gl_volt_q   <= GL_VOLT_RST;
			gh_volt_q   <= GH_VOLT_RST;
			core_volt_q <= CORE_VOLT_RST;
			an_seq_q    <= ANALOG_SEQ_RST;
			gl_pump_q   <= GL_PUMP_RST;
			gh_boost_q  <= GH_BOOST_RST;
			core_seq_q  <= CORE_SEQ_RST;
			rail_en_q   <= RAIL_EN_RST;
		end else if (wr.en) begin
			case (wr.addr)
				GL_VOLT_ADDR:    gl_volt_q   <= wr.data & GL_VOLT_MASK;   // RQ6
				GH_VOLT_ADDR:    gh_volt_q   <= wr.data & GH_VOLT_MASK;   // RQ5
				CORE_VOLT_ADDR:  core_volt_q <= wr.data & CORE_VOLT_MASK; // RQ12
				ANALOG_SEQ_ADDR: an_seq_q    <= wr.data & SEQ_MASK;       // RQ14
				GL_PUMP_ADDR:    gl_pump_q   <= wr.data;                  // RQ11
				GH_BOOST_ADDR:   gh_boost_q  <= wr.data;                  // RQ1
				CORE_SEQ_ADDR:   core_seq_q  <= wr.data & CORE_SEQ_MASK;  // RQ13
				RAIL_EN_ADDR: if (!fault_q) begin
					rail_en_q <= wr.data & RAIL_EN_MASK;                   // RQ17
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		case (reg_addr)
			GL_VOLT_ADDR:    rd_data = gl_volt_q;
			GH_VOLT_ADDR:    rd_data = gh_volt_q;
			CORE_VOLT_ADDR:  rd_data = core_volt_q;
			ANALOG_SEQ_ADDR: rd_data = an_seq_q;
			GL_PUMP_ADDR:    rd_data = gl_pump_q;
			GH_BOOST_ADDR:   rd_data = gh_boost_q;
			CORE_SEQ_ADDR:   rd_data = core_seq_q;
			RAIL_EN_ADDR:    rd_data = rail_en_q;
			STATUS_ADDR:     rd_data = {undervoltage_lockout_s, trip, fault_q, en_q};
			default:         rd_data = 8'h00;
		endcase
	end

	assign o_gate_high_volt    = gh_volt_q[5:0];                      // RQ5
	assign o_gate_high_freq    = gh_boost_q[FREQ_LSB +: 3];           // RQ1
	assign o_gate_low_volt     = gl_volt_q[6:0];                      // RQ6
	assign o_gate_low_full_clk = gl_pump_q[GL_CLK_BIT];               // RQ7
	assign o_gate_low_arch     = gl_pump_q[ARCH_LSB +: 2];            // RQ11
	assign o_core_volt         = core_volt_q[4:0];                    // RQ12

	// ------------------------------------------------------------
	// Millisecond time base since lockout release
	// ------------------------------------------------------------
	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || !undervoltage_lockout_s) begin
			tick_cnt_q <= '0;                                          // RQ16
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;               // RQ16
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || !undervoltage_lockout_s) begin
			elapsed_q <= 8'h00;                                        // RQ16
		end else if (tick && elapsed_q != ELAPSED_MAX) begin
			elapsed_q <= elapsed_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Sequence schedule
	// ------------------------------------------------------------
	always_comb begin
		start_ms[RAIL_AN]   = span_ms(an_seq_q[DLY_LSB +: 3], DLY_STEP_MS, 1'b0);    // RQ15
		ready_ms[RAIL_AN]   = start_ms[RAIL_AN]
			+ span_ms({1'b0, an_seq_q[SS_LSB +: 2]}, AN_SS_MS, 1'b1);               // RQ14
		start_ms[RAIL_GH]   = ready_ms[RAIL_AN]
			+ span_ms(gh_boost_q[DLY_LSB +: 3], DLY_STEP_MS, 1'b0);                 // RQ3
		ready_ms[RAIL_GH]   = start_ms[RAIL_GH]
			+ span_ms({1'b0, gh_boost_q[SS_LSB +: 2]}, GATE_SS_MS, 1'b1);           // RQ2
		start_ms[RAIL_GL]   = start_ms[RAIL_AN]
			+ span_ms(gl_pump_q[DLY_LSB +: 3], DLY_STEP_MS, 1'b0);                  // RQ9
		ready_ms[RAIL_GL]   = start_ms[RAIL_GL]
			+ span_ms({1'b0, gl_pump_q[SS_LSB +: 2]}, GATE_SS_MS, 1'b1);            // RQ8
		start_ms[RAIL_CORE] = span_ms({1'b0, core_seq_q[1:0]}, CORE_STEP_MS, 1'b0); // RQ13
		ready_ms[RAIL_CORE] = start_ms[RAIL_CORE];
		prereq              = {1'b1, en_q[RAIL_AN], rdy_q[RAIL_AN], 1'b1};
	end

	generate
		for (genvar r = 0; r < N_RAILS; r++) begin : g_rail
			always_ff @(posedge i_core_clk) begin
				if (!i_nrst || !undervoltage_lockout_s || fault_q || !rail_en_q[r]) begin
					en_q[r]  <= 1'b0;                                      // RQ17
					rdy_q[r] <= 1'b0;
				end else begin
					if (prereq[r] && elapsed_q >= start_ms[r]) begin
						en_q[r] <= 1'b1;
					end
					if (en_q[r] && elapsed_q >= ready_ms[r]) begin
						rdy_q[r] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	assign o_rail_en   = rail_vec_t'(en_q);
	assign o_rail_ramp = rail_vec_t'(en_q & ~rdy_q);

	// ------------------------------------------------------------
	// Low-output fault timers and shutdown latch
	// ------------------------------------------------------------
	assign watch_rdy = {rdy_q[RAIL_GL], rdy_q[RAIL_GH]};

	generate
		for (genvar f = 0; f < 2; f++) begin : g_fault
			assign trip[f] = tick && (fcnt_q[f] == FAULT_MS - 6'h01);
			always_ff @(posedge i_core_clk) begin
				if (!i_nrst || !undervoltage_lockout_s || !watch_rdy[f] || !low_s[f]) begin
					fcnt_q[f] <= 6'h00;
				end else if (tick && !trip[f]) begin
					fcnt_q[f] <= fcnt_q[f] + 6'h01;                        // RQ4 RQ10
				end
			end
		end
	endgenerate

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			fault_q <= 1'b0;
		end else if (|trip) begin
			fault_q <= 1'b1;                                           // RQ4 RQ10
		end else if (!undervoltage_lockout_s) begin
			fault_q <= 1'b0;                                           // RQ17
		end
	end

	assign o_fault = fault_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	a_fault_kills_en: assert property (fault_q |=> en_q == '0)          // RQ17
		else $error("rail enabled during fault");
	a_en_write_block: assert property (fault_q && wr.en && wr.addr == RAIL_EN_ADDR // RQ17
		|=> $stable(rail_en_q))
		else $error("enable write taken during fault");
	a_fault_hold: assert property (fault_q && undervoltage_lockout_s |=> fault_q)       // RQ4
		else $error("fault released without lockout");
	a_fault_clear: assert property (fault_q && !undervoltage_lockout_s && !(|trip) |=> !fault_q) // RQ10
		else $error("fault kept across lockout");
	a_gh_after_an: assert property ($rose(en_q[RAIL_GH]) // RQ3
		|-> rdy_q[RAIL_AN] && elapsed_q >= start_ms[RAIL_GH])
		else $error("gate-high started early");
	a_gl_after_an: assert property ($rose(en_q[RAIL_GL]) // RQ9
		|-> en_q[RAIL_AN] && elapsed_q >= start_ms[RAIL_GL])
		else $error("gate-low started early");
	a_core_delay: assert property ($rose(en_q[RAIL_CORE]) // RQ13
		|-> elapsed_q >= start_ms[RAIL_CORE])
		else $error("core started early");
	a_lockout_restart: assert property (!undervoltage_lockout_s |=> elapsed_q == 8'h00 && en_q == '0) // RQ16
		else $error("timers not restarted");
	a_trip_sets: assert property (trip[0] |=> fault_q ##1 en_q == '0)   // RQ4
		else $error("gate-high fault not latched");
	a_gl_trip_sets: assert property (trip[1] |=> fault_q ##1 en_q == '0) // RQ10
		else $error("gate-low fault not latched");
	a_reset_codes: assert property ($rose(i_nrst) |-> gh_boost_q == GH_BOOST_RST // RQ1
		&& gl_pump_q == GL_PUMP_RST && gh_volt_q == GH_VOLT_RST)
		else $error("reset codes wrong");

	c_fault: cover property ($rose(fault_q));
	c_gh_ready: cover property ($rose(rdy_q[RAIL_GH]));
	c_gl_ready: cover property ($rose(rdy_q[RAIL_GL]));
	c_core_on: cover property ($rose(en_q[RAIL_CORE]));

endmodule

/* File: src/serial_reg_slave.sv */
// Two-wire serial register slave with auto-incrementing address
`timescale 1ns/10ps
module serial_reg_slave
	import panel_rail_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic [7:0] i_rd_data,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	output logic [7:0]      o_reg_addr,
	output reg_wr_t         o_wr
);

	logic [1:0]    meta_q;
	logic [1:0]    sync_q;
	logic [1:0]    prev_q;
	serial_state_t st_q;
	logic [3:0]    cnt_q;
	logic [7:0]    sh_q;
	logic [7:0]    addr_q;
	logic [7:0]    wdata_q;
	logic          wr_en_q;
	logic          rw_q;
	logic          nack_q;
	logic          scl;
	logic          sda;
	logic          start;
	logic          stop;
	logic          rise;
	logic          fall;
	logic          ack_st;

	// ------------------------------------------------------------
	// Pin synchronisers and bus events
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
			prev_q <= 2'h3;
		end else begin
			meta_q <= {i_scl, i_sda};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign scl   = sync_q[1];
	assign sda   = sync_q[0];
	assign start = scl && prev_q[1] && prev_q[0] && !sda;
	assign stop  = scl && prev_q[1] && !prev_q[0] && sda;
	assign rise  = scl && !prev_q[1];
	assign fall  = !scl && prev_q[1];

	// ------------------------------------------------------------
	// Byte engine
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			st_q    <= S_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			addr_q  <= 8'h00;
			wdata_q <= 8'h00;
			wr_en_q <= 1'b0;
			rw_q    <= 1'b0;
			nack_q  <= 1'b0;
		end else begin
			wr_en_q <= 1'b0;
			if (start) begin
				st_q  <= S_ADDR;
				cnt_q <= 4'h0;
			end else if (stop) begin
				st_q <= S_IDLE;
			end else if (rise) begin
				case (st_q)
					S_ADDR, S_REG, S_WDATA: begin
						sh_q  <= {sh_q[6:0], sda};
						cnt_q <= cnt_q + 4'h1;
					end
					S_RDATA: cnt_q <= cnt_q + 4'h1;
					S_RACKD: nack_q <= sda;
					default: ;
				endcase
			end else if (fall) begin
				case (st_q)
					S_ADDR: if (cnt_q == BYTE_BITS) begin
						cnt_q <= 4'h0;
						rw_q  <= sh_q[0];
						st_q  <= (sh_q[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
					end
					S_AACK: if (rw_q) begin
						st_q <= S_RDATA;
						sh_q <= i_rd_data;
					end else begin
						st_q <= S_REG;
					end
					S_REG: if (cnt_q == BYTE_BITS) begin
						cnt_q  <= 4'h0;
						addr_q <= sh_q;
						st_q   <= S_WACK;
						rw_q   <= 1'b0;
					end
					S_WDATA: if (cnt_q == BYTE_BITS) begin
						cnt_q   <= 4'h0;
						wdata_q <= sh_q;
						wr_en_q <= 1'b1;
						st_q    <= S_WACK;
						rw_q    <= 1'b1;
					end
					S_WACK: begin
						st_q <= S_WDATA;
						if (rw_q) begin
							addr_q <= addr_q + 8'h01;
						end
					end
					S_RDATA: if (cnt_q == BYTE_BITS) begin
						cnt_q  <= 4'h0;
						addr_q <= addr_q + 8'h01;
						st_q   <= S_RACKD;
					end else begin
						sh_q <= {sh_q[6:0], 1'b0};
					end
					S_RACKD: if (nack_q) begin
						st_q <= S_IDLE;
					end else begin
						st_q <= S_RDATA;
						sh_q <= i_rd_data;
					end
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// Open drain: only ever pulls low
	assign ack_st     = (st_q == S_AACK) || (st_q == S_WACK);
	assign o_sda_out  = 1'b0;
	assign o_sda_oe   = ack_st || ((st_q == S_RDATA) && !sh_q[7]);
	assign o_reg_addr = addr_q;
	assign o_wr       = '{en: wr_en_q, addr: addr_q, data: wdata_q};

endmodule

/* File: tb/i2c_host_model.sv */
// Two-wire bus host that reads and writes the sequencer registers
`timescale 1ns/10ps
module i2c_host_model
	import panel_rail_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Each bus phase spans 8 core clocks, twice the slave minimum
	task automatic ph();
		repeat (8) @(negedge i_core_clk);
	endtask
	// Data moves one clock after the fall so it never races the clock line
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		ph();
		o_scl = 1'b1;
		ph();
		r = i_sda;
		o_scl = 1'b0;
		@(negedge i_core_clk);
	endtask
	task automatic start();
		o_sda_low = 1'b0;
		ph();
		o_scl = 1'b1;
		ph();
		o_sda_low = 1'b1;
		ph();
		o_scl = 1'b0;
		@(negedge i_core_clk);
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		ph();
		o_scl = 1'b1;
		ph();
		o_sda_low = 1'b0;
		ph();
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, nak);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak,
			input logic [6:0] dev = DEV_ADDR_DFLT);
		logic [7:0] q;
		logic [2:0] n;
		start();
		xfer({dev, 1'b0}, q, n[0]);
		xfer(a, q, n[1]);
		xfer(d, q, n[2]);
		stop();
		nak = |n;
	endtask
	// Master answers the single data byte with a release, ending the read
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic [3:0] n;
		start();
		xfer({DEV_ADDR_DFLT, 1'b0}, q, n[0]);
		xfer(a, q, n[1]);
		start();
		xfer({DEV_ADDR_DFLT, 1'b1}, q, n[2]);
		xfer(8'hff, d, n[3]);
		stop();
		nak = |n[2:0];
	endtask
endmodule

/* File: tb/panel_rail_sequencer_config_tb_top.sv */
// Self-checking bench: registers, rail schedule and fault shutdown
`timescale 1ns/10ps
module panel_rail_sequencer_config_tb_top
	import panel_rail_pkg::*;
;
	localparam int T = 10;
	logic        i_core_clk;
	logic        i_nrst;
	logic        i_undervoltage_lockout_ok;
	logic        gh_low;
	logic        gl_low;
	logic        scl;
	logic        host_low;
	logic        sda_out;
	logic        sda_oe;
	logic        fault;
	logic        full_clk;
	logic [1:0]  arch;
	logic [5:0]  gh_volt;
	logic [2:0]  gh_freq;
	logic [6:0]  gl_volt;
	logic [4:0]  core_volt;
	logic [23:0] flds;
	rail_vec_t   en;
	rail_vec_t   ramp;
	wire         sda = !(host_low || sda_oe);
	int          err_total;
	int          n_tests;
	int          en_t[4];
	int          rdy_t[4];
	int          flt_t;
	logic [7:0]  d;
	logic        nk;
	logic [7:0]  ra[6] = '{8'h04, 8'h05, 8'h07, 8'h0f, 8'h10, 8'h11};
	logic [7:0]  rv[6] = '{8'h24, 8'h0c, 8'h08, 8'h02, 8'h2a, 8'h24};
	logic [7:0]  rm[6] = '{8'h7f, 8'h3f, 8'h1f, 8'h1f, 8'hff, 8'hff};

	assign flds = {gh_volt, gh_freq, gl_volt, full_clk, arch, core_volt};

	panel_rail_sequencer_config #(
		.TICK_CYCLES (T)
	) dut (
		.i_core_clk          (i_core_clk),
		.i_nrst              (i_nrst),
		.i_scl               (scl),
		.i_sda               (sda),
		.o_sda_out           (sda_out),
		.o_sda_oe            (sda_oe),
		.i_undervoltage_lockout_ok           (i_undervoltage_lockout_ok),
		.i_gate_high_low     (gh_low),
		.i_gate_low_low      (gl_low),
		.o_rail_en           (en),
		.o_rail_ramp         (ramp),
		.o_fault             (fault),
		.o_gate_high_volt    (gh_volt),
		.o_gate_high_freq    (gh_freq),
		.o_gate_low_volt     (gl_volt),
		.o_gate_low_full_clk (full_clk),
		.o_gate_low_arch     (arch),
		.o_core_volt         (core_volt)
	);

	i2c_host_model host (
		.i_core_clk (i_core_clk),
		.i_sda      (sda),
		.o_scl      (scl),
		.o_sda_low  (host_low)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = !i_core_clk;
	end

	// ------------------------------------------------------------
	// Compare and report helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	// Event cycle against a millisecond target, allowing sync and tick phase
	task automatic win(input int got, input int ms);
		rng(got, ms * T, ms * T + T + 5);
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Releases lockout and logs enable, ready and fault cycles
	task automatic run(input int n, input int fc);
		rail_vec_t pr;
		int        cyc;
		cyc = 0;
		flt_t = -1;
		pr = '0;
		for (int i = 0; i < 4; i++) begin
			en_t[i] = -1;
			rdy_t[i] = -1;
		end
		i_undervoltage_lockout_ok = 1'b1;
		repeat (n) begin
			@(negedge i_core_clk);
			cyc++;
			if (cyc == fc)
				gh_low = 1'b1;
			for (int i = 0; i < 4; i++) begin
				if (en_t[i] < 0 && en[i] === 1'b1)
					en_t[i] = cyc;
				if (rdy_t[i] < 0 && pr[i] && ramp[i] === 1'b0)
					rdy_t[i] = cyc;
			end
			if (flt_t < 0 && fault === 1'b1)
				flt_t = cyc;
			pr = ramp;
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_nrst = 1'b0;
		i_undervoltage_lockout_ok = 1'b0;
		gh_low = 1'b0;
		gl_low = 1'b0;
		err_total = 0;
		n_tests = 0;
		repeat (20) @(negedge i_core_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_core_clk);
		chk(flds, {6'h0c, 3'h1, 7'h24, 1'b1, 2'h0, 5'h08});
		chk({sda_out, sda_oe, fault, en}, 7'h00);
		for (int i = 0; i < 6; i++) begin
			host.rd(ra[i], d, nk);
			chk({nk, d}, {1'b0, rv[i]});
		end
		host.wr(8'h05, 8'h01, nk, 7'h2d);
		chk(nk, 1'b1);
		host.rd(8'h05, d, nk);
		chk(d, 8'h0c);
		host.rd(8'h30, d, nk);
		chk(d, 8'h00);
		for (int i = 0; i < 6; i++) begin
			host.wr(ra[i], 8'hff, nk);
			host.rd(ra[i], d, nk);
			chk(d, rm[i]);
		end
		chk(flds, {6'h3f, 3'h7, 7'h7f, 1'b1, 2'h3, 5'h1f});
		host.wr(8'h10, 8'h40, nk);
		chk({full_clk, arch}, 3'b001);
		i_nrst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_core_clk);
		chk(flds, {6'h0c, 3'h1, 7'h24, 1'b1, 2'h0, 5'h08});
		chk({sda_out, sda_oe, fault, en}, 7'h00);
		run(102 * T + 20, 40 * T);
		win(en_t[RAIL_AN], 10);
		win(rdy_t[RAIL_AN], 15);
		win(en_t[RAIL_GH], 35);
		win(rdy_t[RAIL_GH], 37);
		win(en_t[RAIL_GL], 20);
		win(rdy_t[RAIL_GL], 24);
		win(en_t[RAIL_CORE], 3);
		rng(flt_t - 40 * T, 59 * T, 61 * T + 5);
		chk(en, 4'h0);
		host.wr(8'h21, 8'h00, nk);
		host.rd(8'h21, d, nk);
		chk(d, 8'h0f);
		host.rd(8'h22, d, nk);
		chk(d[4], 1'b1);
		i_undervoltage_lockout_ok = 1'b0;
		gh_low = 1'b0;
		repeat (6) @(negedge i_core_clk);
		chk({fault, en}, 5'h00);
		host.wr(8'h0f, 8'h0b, nk);
		host.wr(8'h11, 8'h18, nk);
		host.wr(8'h10, 8'h2f, nk);
		host.wr(8'h20, 8'h03, nk);
		host.wr(8'h05, 8'h14, nk);
		chk({gh_freq, gh_volt}, {3'h0, 6'h14});
		gl_low = 1'b1;
		run(120 * T, 0);
		win(en_t[RAIL_AN], 15);
		win(rdy_t[RAIL_AN], 25);
		win(en_t[RAIL_GH], 25);
		win(rdy_t[RAIL_GH], 33);
		win(en_t[RAIL_GL], 50);
		win(rdy_t[RAIL_GL], 54);
		win(en_t[RAIL_CORE], 9);
		rng(flt_t - rdy_t[RAIL_GL], 59 * T - 2, 61 * T + 5);
		chk(en, 4'h0);
		i_undervoltage_lockout_ok = 1'b0;
		gl_low = 1'b0;
		repeat (6) @(negedge i_core_clk);
		chk({fault, en}, 5'h00);
		host.wr(8'h21, 8'h07, nk);
		run(60 * T, 0);
		win(en_t[RAIL_AN], 15);
		win(en_t[RAIL_GL], 50);
		chk({fault, en}, 5'h07);
		i_undervoltage_lockout_ok = 1'b0;
		end_of_test();
	end
endmodule
